// ---- hw/rivc_defines.vh ----
// constants for the reset and interrupt vectoring block
// Overview of operation
// - three reset vectors (pin/power-on, clock monitor, watchdog) plus 18 interrupt vectors
// - 22 sources share those vectors: three nonmaskable, nineteen maskable
// - nonmaskable pin, illegal opcode and software interrupt each own a vector
// - maskable requests only taken while global mask bit clear, else stay pending
// - fixed default priority; priority register promotes one source to top
// - priority register written only while global mask bit is set
// - maskable sources except external request pin need their local enable
// - rx full flag clears on status read while set, then data read
// - all async serial requests share one vector, gated by rx/tx enables
// - synchronous serial transfer complete vectors at FFD8
// - pulse accumulator input edge vectors at FFDA
// - pulse accumulator overflow vectors at FFDC
// - timer overflow vectors at FFDE
// - input capture 4 / output compare 5 vectors at FFE0
`ifndef RIVC_DEFINES_VH
`define RIVC_DEFINES_VH

// ----------------------------------------
// vector addresses
// ----------------------------------------
`define RIVC_VEC_SSP_DONE   16'hFFD8
`define RIVC_VEC_PACC_EDGE  16'hFFDA
`define RIVC_VEC_PACC_OVF   16'hFFDC
`define RIVC_VEC_TMR_OVF    16'hFFDE
`define RIVC_VEC_IC4_OC5    16'hFFE0
`define RIVC_VEC_OC4        16'hFFE2
`define RIVC_VEC_OC3        16'hFFE4
`define RIVC_VEC_OC2        16'hFFE6
`define RIVC_VEC_OC1        16'hFFE8
`define RIVC_VEC_IC3        16'hFFEA
`define RIVC_VEC_IC2        16'hFFEC
`define RIVC_VEC_IC1        16'hFFEE
`define RIVC_VEC_RTI        16'hFFF0
`define RIVC_VEC_EXT_IRQ    16'hFFF2
`define RIVC_VEC_NMI_PIN    16'hFFF4
`define RIVC_VEC_SWI        16'hFFF6
`define RIVC_VEC_ILLOP      16'hFFF8
`define RIVC_VEC_WDOG       16'hFFFA
`define RIVC_VEC_CLKMON     16'hFFFC
`define RIVC_VEC_RESET      16'hFFFE
`define RIVC_VEC_ASYNC      16'hFFD6

// ----------------------------------------
// maskable source indices, default priority (0 highest)
// ----------------------------------------
`define RIVC_NSRC           5'h0F
`define RIVC_SRC_EXT_IRQ    4'h0
`define RIVC_SRC_RTI        4'h1
`define RIVC_SRC_IC1        4'h2
`define RIVC_SRC_IC2        4'h3
`define RIVC_SRC_IC3        4'h4
`define RIVC_SRC_OC1        4'h5
`define RIVC_SRC_OC2        4'h6
`define RIVC_SRC_OC3        4'h7
`define RIVC_SRC_OC4        4'h8
`define RIVC_SRC_IC4_OC5    4'h9
`define RIVC_SRC_TMR_OVF    4'hA
`define RIVC_SRC_PACC_OVF   4'hB
`define RIVC_SRC_PACC_EDGE  4'hC
`define RIVC_SRC_SSP_DONE   4'hD
`define RIVC_SRC_ASYNC      4'hE
`define RIVC_PRIO_RESET     4'h0

// ----------------------------------------
// vector kinds
// ----------------------------------------
`define RIVC_KIND_NONE      3'h0
`define RIVC_KIND_RESET     3'h1
`define RIVC_KIND_NMI       3'h2
`define RIVC_KIND_MASKABLE  3'h3

`endif

// ---- hw/rivc_sync.v ----
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
module rivc_sync (
    input  wire clk_i,
    input  wire rst_i,
    input  wire din_i,
    output reg  dout_o
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_r   <= 1'b0;
            s2_r   <= 1'b0;
            s3_r   <= 1'b0;
            dout_o <= 1'b0;
        end else begin
            s1_r <= din_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // only a settled level counts
            if (s2_r == s3_r) begin
                dout_o <= s3_r;
            end
        end
    end
endmodule // rivc_sync
`default_nettype wire

// ---- hw/rivc_rx_flag.v ----
// receive-full flag with status-then-data read clearing
`timescale 1ns/1ps
`default_nettype none
module rivc_rx_flag (
    input  wire clk_i,
    input  wire rst_i,
    input  wire set_i,
    input  wire stat_rd_i,
    input  wire data_rd_i,
    output reg  flag_o
);
    reg armed_r;

    always @(posedge clk_i) begin
        if (rst_i) begin
            flag_o  <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            // set wins over the clear so a new byte is not lost
            if (set_i) begin
                flag_o <= 1'b1;
            end else if (data_rd_i && armed_r) begin
                flag_o <= 1'b0;
            end
            if (data_rd_i || set_i) begin
                armed_r <= 1'b0;
            end else if (stat_rd_i && flag_o) begin
                armed_r <= 1'b1;
            end
        end
    end
endmodule // rivc_rx_flag
`default_nettype wire

// ---- hw/rivc_top.v ----
// reset and interrupt vector selection toward the cpu core
`include "rivc_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module rivc_top (
    input  wire        CLK_SYS_I,
    input  wire        RST_I,
    input  wire        POR_I,
    input  wire        CLKMON_FAIL_I,
    input  wire        WATCHDOG_FAILURE_I,
    input  wire        NONMASKABLE_REQUEST_PIN_N_I,
    input  wire        EXT_IRQ_N_I,
    input  wire        ILLOP_TRAP_I,
    input  wire        SWI_TRAP_I,
    input  wire        CCR_I_MASK_I,
    input  wire        CCR_X_MASK_I,
    input  wire [13:0] PERIPH_REQ_I,
    input  wire [13:0] PERIPH_EN_I,
    input  wire        RX_FULL_SET_I,
    input  wire        RX_OVERRUN_I,
    input  wire        TX_EMPTY_I,
    input  wire        TX_DONE_I,
    input  wire        IDLE_LINE_I,
    input  wire        RX_INTERRUPT_ENABLE_I,
    input  wire        TX_INTERRUPT_ENABLE_I,
    input  wire        SER_STAT_RD_I,
    input  wire        SER_DATA_RD_I,
    input  wire        PRIO_WR_I,
    input  wire [3:0]  PRIO_WDATA_I,
    input  wire        VEC_ACK_I,
    input  wire [15:0] FETCH_ADDR_I,
    output reg         REQ_O,
    output reg  [2:0]  REQ_KIND_O,
    output reg  [15:0] VEC_ADDR_O,
    output reg  [4:0]  REQ_SRC_O,
    output reg  [3:0]  PRIORITY_PROMOTION_REGISTER_O,
    output reg         RX_FULL_FLAG_O,
    output reg         PRIO_WR_REJ_O,
    output reg  [7:0]  VEC_BYTE_O
);
    // ----------------------------------------
    // vector table (pairs of bytes)
    // ----------------------------------------
    function [15:0] vec_of;
        input [3:0] src;
        begin
            case (src)
                `RIVC_SRC_EXT_IRQ:   vec_of = `RIVC_VEC_EXT_IRQ;
                `RIVC_SRC_RTI:       vec_of = `RIVC_VEC_RTI;
                `RIVC_SRC_IC1:       vec_of = `RIVC_VEC_IC1;
                `RIVC_SRC_IC2:       vec_of = `RIVC_VEC_IC2;
                `RIVC_SRC_IC3:       vec_of = `RIVC_VEC_IC3;
                `RIVC_SRC_OC1:       vec_of = `RIVC_VEC_OC1;
                `RIVC_SRC_OC2:       vec_of = `RIVC_VEC_OC2;
                `RIVC_SRC_OC3:       vec_of = `RIVC_VEC_OC3;
                `RIVC_SRC_OC4:       vec_of = `RIVC_VEC_OC4;
                `RIVC_SRC_IC4_OC5:   vec_of = `RIVC_VEC_IC4_OC5;
                `RIVC_SRC_TMR_OVF:   vec_of = `RIVC_VEC_TMR_OVF;
                `RIVC_SRC_PACC_OVF:  vec_of = `RIVC_VEC_PACC_OVF;
                `RIVC_SRC_PACC_EDGE: vec_of = `RIVC_VEC_PACC_EDGE;
                `RIVC_SRC_SSP_DONE:  vec_of = `RIVC_VEC_SSP_DONE;
                `RIVC_SRC_ASYNC:     vec_of = `RIVC_VEC_ASYNC;
                default:             vec_of = `RIVC_VEC_ASYNC;
            endcase
        end
    endfunction

    // handler address bytes are an external memory; expose the byte lane
    function [7:0] byte_lane;
        input [15:0] word;
        input        odd;
        begin
            byte_lane = odd ? word[7:0] : word[15:8];
        end
    endfunction

    // an acknowledge retires a latched cause only while the shown vector names it
    function acked;
        input        ack;
        input        pend;
        input [15:0] shown;
        input [15:0] cause;
        begin
            acked = ack && pend && (shown == cause);
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    wire nmi_pin_n_s;
    wire ext_irq_n_s;

    rivc_sync u_sync_nmi (
        .clk_i  (CLK_SYS_I),
        .rst_i  (RST_I),
        .din_i  (NONMASKABLE_REQUEST_PIN_N_I),
        .dout_o (nmi_pin_n_s)
    );

    rivc_sync u_sync_irq (
        .clk_i  (CLK_SYS_I),
        .rst_i  (RST_I),
        .din_i  (EXT_IRQ_N_I),
        .dout_o (ext_irq_n_s)
    );

    // ----------------------------------------
    // serial receive flag
    // ----------------------------------------
    wire rx_full;

    rivc_rx_flag u_rx_flag (
        .clk_i     (CLK_SYS_I),
        .rst_i     (RST_I),
        .set_i     (RX_FULL_SET_I),
        .stat_rd_i (SER_STAT_RD_I),
        .data_rd_i (SER_DATA_RD_I),
        .flag_o    (rx_full)
    );

    // ----------------------------------------
    // priority promotion register
    // ----------------------------------------
    reg  [3:0] prio_r;
    wire       prio_ok = PRIO_WR_I && CCR_I_MASK_I;

    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            prio_r <= `RIVC_PRIO_RESET;
        end else if (prio_ok && (PRIO_WDATA_I < `RIVC_NSRC)) begin
            prio_r <= PRIO_WDATA_I;
        end
    end

    // ----------------------------------------
    // maskable request vector
    // ----------------------------------------
    wire        async_req = (RX_INTERRUPT_ENABLE_I && (rx_full || RX_OVERRUN_I || IDLE_LINE_I))
                          || (TX_INTERRUPT_ENABLE_I && (TX_EMPTY_I || TX_DONE_I));
    // only thirteen peripherals feed this lane; the top request and enable bits carry nothing
    wire [12:0] periph_live = PERIPH_REQ_I[12:0] & PERIPH_EN_I[12:0];
    wire [14:0] mreq = {async_req,
                        periph_live,
                        ~ext_irq_n_s};                 // no local enable on the pin

    // ----------------------------------------
    // arbitration
    // ----------------------------------------
    reg [3:0] win_src;
    reg       win_any;
    integer   k;

    always @* begin
        win_src = 4'h0;
        win_any = 1'b0;
        // scan from highest to lowest so the last hit (lowest index) is the winner
        for (k = 14; k >= 0; k = k - 1) begin
            if (mreq[k]) begin
                win_src = k[3:0];
                win_any = 1'b1;
            end
        end
        if (mreq[prio_r]) begin
            win_src = prio_r;
            win_any = 1'b1;
        end
    end

    // ----------------------------------------
    // request selection: resets, then nonmaskables, then maskables
    // ----------------------------------------
    reg        pend_r;
    reg        por_seen_r;
    reg        illop_r;
    reg        swi_r;
    reg        req_nxt;
    reg [2:0]  kind_nxt;
    reg [15:0] vec_nxt;
    reg [4:0]  src_nxt;

    always @* begin
        req_nxt  = 1'b0;
        kind_nxt = `RIVC_KIND_NONE;
        vec_nxt  = `RIVC_VEC_RESET;
        src_nxt  = 5'h1F;
        if (por_seen_r || POR_I) begin
            req_nxt  = 1'b1;
            kind_nxt = `RIVC_KIND_RESET;
            vec_nxt  = `RIVC_VEC_RESET;
        end else if (CLKMON_FAIL_I) begin
            req_nxt  = 1'b1;
            kind_nxt = `RIVC_KIND_RESET;
            vec_nxt  = `RIVC_VEC_CLKMON;
        end else if (WATCHDOG_FAILURE_I) begin
            req_nxt  = 1'b1;
            kind_nxt = `RIVC_KIND_RESET;
            vec_nxt  = `RIVC_VEC_WDOG;
        end else if (illop_r) begin
            req_nxt  = 1'b1;
            kind_nxt = `RIVC_KIND_NMI;
            vec_nxt  = `RIVC_VEC_ILLOP;
        end else if (swi_r) begin
            req_nxt  = 1'b1;
            kind_nxt = `RIVC_KIND_NMI;
            vec_nxt  = `RIVC_VEC_SWI;
        end else if (!nmi_pin_n_s && !CCR_X_MASK_I) begin
            req_nxt  = 1'b1;
            kind_nxt = `RIVC_KIND_NMI;
            vec_nxt  = `RIVC_VEC_NMI_PIN;
        end else if (win_any && !CCR_I_MASK_I) begin
            req_nxt  = 1'b1;
            kind_nxt = `RIVC_KIND_MASKABLE;
            vec_nxt  = vec_of(win_src);
            src_nxt  = {1'b0, win_src};
        end
    end

    // ----------------------------------------
    // trap and reset-cause latches
    // ----------------------------------------
    // a cause pulsing on the ack edge must not be lost, so each set wins over its clear
    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            por_seen_r <= 1'b1;
            illop_r    <= 1'b0;
            swi_r      <= 1'b0;
        end else begin
            if (POR_I) begin
                por_seen_r <= 1'b1;
            end else if (VEC_ACK_I && pend_r && REQ_KIND_O == `RIVC_KIND_RESET) begin
                por_seen_r <= 1'b0;
            end
            if (ILLOP_TRAP_I) begin
                illop_r <= 1'b1;
            end else if (acked(VEC_ACK_I, pend_r, VEC_ADDR_O, `RIVC_VEC_ILLOP)) begin
                illop_r <= 1'b0;
            end
            if (SWI_TRAP_I) begin
                swi_r <= 1'b1;
            end else if (acked(VEC_ACK_I, pend_r, VEC_ADDR_O, `RIVC_VEC_SWI)) begin
                swi_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // request register
    // ----------------------------------------
    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            pend_r     <= 1'b0;
            REQ_O      <= 1'b0;
            REQ_KIND_O <= `RIVC_KIND_NONE;
            VEC_ADDR_O <= `RIVC_VEC_RESET;
            REQ_SRC_O  <= 5'h1F;
        end else begin
            // held while the cpu fetches; peripherals drop their own request
            if (!pend_r || VEC_ACK_I) begin
                pend_r     <= req_nxt && !VEC_ACK_I;
                REQ_O      <= req_nxt && !VEC_ACK_I;
                REQ_KIND_O <= VEC_ACK_I ? `RIVC_KIND_NONE : kind_nxt;
                VEC_ADDR_O <= vec_nxt;
                REQ_SRC_O  <= VEC_ACK_I ? 5'h1F : src_nxt;
            end
        end
    end

    // ----------------------------------------
    // status outputs
    // ----------------------------------------
    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            PRIORITY_PROMOTION_REGISTER_O <= `RIVC_PRIO_RESET;
            RX_FULL_FLAG_O                <= 1'b0;
            PRIO_WR_REJ_O                 <= 1'b0;
            VEC_BYTE_O                    <= 8'h00;
        end else begin
            PRIORITY_PROMOTION_REGISTER_O <= prio_r;
            RX_FULL_FLAG_O                <= rx_full;
            PRIO_WR_REJ_O                 <= PRIO_WR_I && !CCR_I_MASK_I;
            VEC_BYTE_O                    <= byte_lane(VEC_ADDR_O, FETCH_ADDR_I[0]);
        end
    end
endmodule // rivc_top
`default_nettype wire

// ---- test/rivc_properties.sv ----
// port checker for the vectoring block
`timescale 1ns/1ps
`default_nettype none
module rivc_properties (
    input wire logic        CLK_SYS_I,
    input wire logic        RST_I,
    input wire logic        CCR_I_MASK_I,
    input wire logic        PRIO_WR_I,
    input wire logic [3:0]  PRIO_WDATA_I,
    input wire logic        VEC_ACK_I,
    input wire logic [15:0] FETCH_ADDR_I,
    input wire logic        RX_FULL_SET_I,
    input wire logic        REQ_O,
    input wire logic [2:0]  REQ_KIND_O,
    input wire logic [15:0] VEC_ADDR_O,
    input wire logic [4:0]  REQ_SRC_O,
    input wire logic [3:0]  PRIORITY_PROMOTION_REGISTER_O,
    input wire logic        RX_FULL_FLAG_O,
    input wire logic        PRIO_WR_REJ_O,
    input wire logic [7:0]  VEC_BYTE_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    // ----
    // fetch side, priority register and rx flag
    // ----
    logic odd_r;
    always_ff @(posedge CLK_SYS_I) odd_r <= FETCH_ADDR_I[0];
    req_hold_a: assert property (REQ_O && !VEC_ACK_I |=> REQ_O && $stable(VEC_ADDR_O))
        else $error("vector changed before ack");
    ack_release_a: assert property (REQ_O && VEC_ACK_I |=> !REQ_O)
        else $error("request kept after ack");
    mask_gate_a: assert property ($rose(REQ_O) && REQ_KIND_O == 3'h3 |-> !$past(CCR_I_MASK_I))
        else $error("maskable taken while masked");
    vec_even_a: assert property (REQ_O |-> !VEC_ADDR_O[0])
        else $error("odd vector address");
    byte_pick_a: assert property (REQ_O && !VEC_ACK_I |=>
        VEC_BYTE_O == (odd_r ? VEC_ADDR_O[7:0] : VEC_ADDR_O[15:8]))
        else $error("wrong vector byte");
    prio_reject_a: assert property (PRIO_WR_I && !CCR_I_MASK_I |=>
        PRIO_WR_REJ_O && $stable(PRIORITY_PROMOTION_REGISTER_O))
        else $error("priority write not refused");
    prio_write_a: assert property (PRIO_WR_I && CCR_I_MASK_I && PRIO_WDATA_I < 4'hF |-> ##2
        PRIORITY_PROMOTION_REGISTER_O == $past(PRIO_WDATA_I, 2))
        else $error("priority write lost");
    vec_map_a: assert property (REQ_O && REQ_KIND_O == 3'h3 |->
        VEC_ADDR_O == 16'hFFF2 - {10'h000, REQ_SRC_O, 1'b0})
        else $error("maskable vector mismatch");
    rx_set_a: assert property (RX_FULL_SET_I |-> ##2 RX_FULL_FLAG_O)
        else $error("rx full flag not set");
    nmi_kind_a: assert property (REQ_O && REQ_KIND_O == 3'h2 |-> REQ_SRC_O == 5'h1F &&
        VEC_ADDR_O inside {16'hFFF4, 16'hFFF6, 16'hFFF8})
        else $error("nonmaskable vector mismatch");
    cover property ($rose(REQ_O) && REQ_KIND_O == 3'h2);
    cover property ($rose(REQ_O) && REQ_SRC_O == 5'h0E);
    cover property (PRIO_WR_REJ_O);
    cover property ($fell(RX_FULL_FLAG_O));
endmodule // rivc_properties
bind rivc_top rivc_properties i_props (.*);
`default_nettype wire

// ---- test/rivc_cpu_model.sv ----
// cpu core model: fetches both vector bytes, then acks
`timescale 1ns/1ps
`default_nettype none
module rivc_cpu_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic [15:0] vec_i,
    input  wire logic [7:0]  byte_i,
    input  wire logic [3:0]  wait_i,
    output var  logic        ack_o,
    output var  logic [15:0] addr_o,
    output var  logic [15:0] word_o,
    output var  logic        got_o
);
    int st;
    int cnt;
    always @(negedge clk_i) begin
        ack_o <= 1'b0;
        got_o <= 1'b0;
        if (rst_i) begin
            st <= 0;
            addr_o <= 16'h0000;
        end else begin
            case (st)
                // idle bus keeps moving so a stale address is never trusted
                0: begin
                    addr_o <= ~addr_o;
                    cnt <= 0;
                    if (req_i) st <= 1;
                end
                1: if (cnt >= wait_i) begin
                    addr_o <= vec_i;
                    st <= 2;
                end else cnt <= cnt + 1;
                2: begin
                    word_o[15:8] <= byte_i;
                    addr_o <= vec_i | 16'h0001;
                    st <= 3;
                end
                default: begin
                    word_o[7:0] <= byte_i;
                    ack_o <= 1'b1;
                    got_o <= 1'b1;
                    st <= 0;
                end
            endcase
        end
    end
endmodule // rivc_cpu_model
`default_nettype wire

// ---- test/rivc_tb_top.sv ----
// self-checking bench for the vectoring block
`timescale 1ns/1ps
`default_nettype none
module rivc_tb_top;
    logic        clk = 1'b0, rst = 1'b1, por = 1'b0, cmf = 1'b0, wdf = 1'b0, nmi_n = 1'b1, irq_n = 1'b1;
    logic        ill = 1'b0, swi = 1'b0, imask = 1'b1, ovr = 1'b0, txe = 1'b0, txd = 1'b0, idl = 1'b0;
    logic        rxs = 1'b0, rx_interrupt_enable = 1'b0, tx_interrupt_enable = 1'b0, srd = 1'b0, drd = 1'b0, pwr = 1'b0, xm = 1'b0;
    logic [13:0] preq = 14'h0000, pen = 14'h0000;
    logic [3:0]  pwd = 4'h0, wt = 4'h0, prio;
    logic [15:0] fa, word, vaddr;
    logic [31:0] rs = 32'h633888DA;
    logic [7:0]  vb;
    logic [4:0]  src;
    logic [2:0]  kind;
    logic        ack, got, req, rej, rxf;
    int          failures = 0, compares = 0, cyc = 0;
    rivc_top i_dut (.CLK_SYS_I(clk), .RST_I(rst), .POR_I(por), .CLKMON_FAIL_I(cmf), .WATCHDOG_FAILURE_I(wdf),
        .NONMASKABLE_REQUEST_PIN_N_I(nmi_n), .EXT_IRQ_N_I(irq_n), .ILLOP_TRAP_I(ill), .SWI_TRAP_I(swi),
        .CCR_I_MASK_I(imask), .CCR_X_MASK_I(xm), .PERIPH_REQ_I(preq), .PERIPH_EN_I(pen),
        .RX_FULL_SET_I(rxs), .RX_OVERRUN_I(ovr), .TX_EMPTY_I(txe), .TX_DONE_I(txd), .IDLE_LINE_I(idl),
        .RX_INTERRUPT_ENABLE_I(rx_interrupt_enable), .TX_INTERRUPT_ENABLE_I(tx_interrupt_enable), .SER_STAT_RD_I(srd), .SER_DATA_RD_I(drd),
        .PRIO_WR_I(pwr), .PRIO_WDATA_I(pwd), .VEC_ACK_I(ack), .FETCH_ADDR_I(fa), .REQ_O(req),
        .REQ_KIND_O(kind), .VEC_ADDR_O(vaddr), .REQ_SRC_O(src), .PRIORITY_PROMOTION_REGISTER_O(prio),
        .RX_FULL_FLAG_O(rxf), .PRIO_WR_REJ_O(rej), .VEC_BYTE_O(vb));
    rivc_cpu_model i_cpu (.clk_i(clk), .rst_i(rst), .req_i(req), .vec_i(vaddr), .byte_i(vb), .wait_i(wt),
        .ack_o(ack), .addr_o(fa), .word_o(word), .got_o(got));
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            finish_test();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [15:0] vec(input int i);
        return 16'hFFF2 - 16'(2 * i);
    endfunction
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic quiet(input int c);
        repeat (c) begin
            @(negedge clk);
            chk("idle req", 16'(req), 16'h0000);
        end
    endtask
    // ----
    // one vector fetch; the handler drops its cause before the ack lands
    // ----
    task automatic deliver(input logic [15:0] w, input logic [2:0] k, input logic [4:0] s);
        int n;
        n = 0;
        while (req !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk("kind", 16'(kind), 16'(k));
        chk("source", 16'(src), 16'(s));
        chk("vector", vaddr, w);
        n = 0;
        while (got !== 1'b1 && n < 60) begin
            @(negedge clk);
            #1;
            n++;
        end
        chk("fetched", word, w);
        if (w == 16'hFFFC) cmf = 1'b0;
        if (w == 16'hFFFA) wdf = 1'b0;
        // the core masks a level pin on entry; the synchroniser still shows it low for a few cycles
        if (w == 16'hFFF4) {nmi_n, xm} = 2'b11;
        if (k == 3'h3 && s == 5'h00) {irq_n, imask} = 2'b11;
        if (k == 3'h3 && s > 5'h00 && s < 5'h0E) preq[s - 1] = 1'b0;
        if (s == 5'h0E) {ovr, txe, txd, idl, rx_interrupt_enable, tx_interrupt_enable} = 6'h00;
        // let the ack edge pass so the next call does not see the retiring request
        @(negedge clk);
    endtask
    initial begin
        int m, e, p;
        int q[$];
        repeat (6) @(negedge clk);
        rst = 1'b0;
        deliver(16'hFFFE, 3'h1, 5'h1F);
        {cmf, wdf} = 2'b11;
        deliver(16'hFFFC, 3'h1, 5'h1F);
        deliver(16'hFFFA, 3'h1, 5'h1F);
        por = 1'b1;
        @(negedge clk);
        por = 1'b0;
        deliver(16'hFFFE, 3'h1, 5'h1F);
        {ill, swi, nmi_n} = 3'b110;
        @(negedge clk);
        {ill, swi} = 2'b00;
        deliver(16'hFFF8, 3'h2, 5'h1F);
        deliver(16'hFFF6, 3'h2, 5'h1F);
        deliver(16'hFFF4, 3'h2, 5'h1F);
        $display("reset and nonmaskable test done");
        for (int i = 1; i < 14; i++) begin
            rs = xs(rs);
            {imask, irq_n} = 2'b01;
            pen = rs[13:0] & ~(14'h0001 << (i - 1));
            preq[i - 1] = 1'b1;
            quiet(8);
            imask = 1'b1;
            pen[i - 1] = 1'b1;
            quiet(8);
            imask = 1'b0;
            deliver(vec(i), 3'h3, 5'(i));
        end
        {pen, irq_n} = 15'h0000;
        deliver(16'hFFF2, 3'h3, 5'h00);
        $display("single source test done");
        for (int t = 0; t < 6; t++) begin
            rs = xs(rs);
            imask = 1'b1;
            p = 1 + rs[7:0] % 13;
            {pwr, pwd} = {1'b1, 4'(p)};
            @(negedge clk);
            pwr = 1'b0;
            @(negedge clk);
            chk("promoted", 16'(prio), 16'(p));
            preq[12:0] = rs[20:8] | 13'h0001;
            pen = 14'h3FFF;
            wt = rs[27:24];
            m = int'(preq);
            while (m != 0) begin
                e = 1;
                while (((m >> (e - 1)) & 1) == 0) e++;
                if (((m >> (p - 1)) & 1) == 1) e = p;
                q.push_back(e);
                m = m & ~(1 << (e - 1));
            end
            imask = 1'b0;
            foreach (q[j]) deliver(vec(q[j]), 3'h3, 5'(q[j]));
            q.delete();
            {pwr, pwd} = {1'b1, 4'(p + 1)};
            @(negedge clk);
            pwr = 1'b0;
            chk("refused", 16'(rej), 16'h0001);
            chk("kept", 16'(prio), 16'(p));
        end
        $display("priority test done");
        wt = 4'h0;
        {ovr, tx_interrupt_enable} = 2'b11;
        quiet(8);
        rx_interrupt_enable = 1'b1;
        deliver(16'hFFD6, 3'h3, 5'h0E);
        {txe, rx_interrupt_enable} = 2'b11;
        quiet(8);
        tx_interrupt_enable = 1'b1;
        deliver(16'hFFD6, 3'h3, 5'h0E);
        {txd, rx_interrupt_enable, tx_interrupt_enable} = 3'b111;
        deliver(16'hFFD6, 3'h3, 5'h0E);
        {idl, rx_interrupt_enable, tx_interrupt_enable} = 3'b111;
        deliver(16'hFFD6, 3'h3, 5'h0E);
        {rxs, rx_interrupt_enable} = 2'b11;
        @(negedge clk);
        rxs = 1'b0;
        deliver(16'hFFD6, 3'h3, 5'h0E);
        chk("rx flag set", 16'(rxf), 16'h0001);
        drd = 1'b1;
        @(negedge clk);
        drd = 1'b0;
        quiet(2);
        chk("rx flag kept", 16'(rxf), 16'h0001);
        srd = 1'b1;
        @(negedge clk);
        {srd, drd} = 2'b01;
        @(negedge clk);
        drd = 1'b0;
        quiet(2);
        chk("rx flag cleared", 16'(rxf), 16'h0000);
        $display("serial test done");
        finish_test();
    end
endmodule // rivc_tb_top
`default_nettype wire
